// ---- common/ied_evt_if.sv ----
// carrier between the register top, the flag store and the interrupt gate
`timescale 1ns/10ps
`default_nettype none
interface ied_evt_if;
    logic [7:0] err_set;
    logic [7:0] err_clr;
    logic coll_set;
    logic coll_clr;
    logic [6:0] coll_pos;
    logic [7:0] err_flags;
    logic [7:0] coll_reg;
    logic [7:0] irq_en2;
    logic irq_inv;
    logic req_cd;
    logic [4:0] req_tmr;
    logic combined;
    logic pin_o;
    logic pin_oe;
    modport top_m(output err_set, err_clr, coll_set, coll_clr, coll_pos, irq_en2, irq_inv,
        req_cd, req_tmr, input err_flags, coll_reg, combined, pin_o, pin_oe);
    modport flag_m(input err_set, err_clr, coll_set, coll_clr, coll_pos,
        output err_flags, coll_reg);
    modport irq_m(input irq_en2, irq_inv, req_cd, req_tmr, output combined, pin_o, pin_oe);
endinterface
`default_nettype wire

// ---- common/ied_pkg.sv ----
// shared constants, register map and state codes of the error and interrupt-enable block
package ied_pkg;
    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [7:0] IED_IDX_IRQ_EN2 = 8'h09;
    localparam logic [7:0] IED_IDX_ERROR = 8'h0A;
    localparam logic [7:0] IED_IDX_STATUS = 8'h0B;
    localparam logic [7:0] IED_IDX_COLL = 8'h0D;
    localparam logic [7:0] IED_IDX_CTRL = 8'h10;
    // ==========================================================
    // field positions
    localparam int IED_EN_DRIVE = 7;
    localparam int IED_EN_GATE = 6;
    localparam int IED_EN_CD = 5;
    localparam int IED_ERR_NVM = 7;
    localparam int IED_ERR_MISUSE = 6;
    localparam int IED_ERR_OVL = 5;
    localparam int IED_ERR_SHORT = 4;
    localparam int IED_ERR_EMPTY = 3;
    localparam int IED_ERR_COLL = 2;
    localparam int IED_ERR_PROT = 1;
    localparam int IED_ERR_INTEG = 0;
    localparam int IED_CTL_INV = 0;
    localparam int IED_CTL_COLLINT = 1;
    localparam int IED_CTL_MRX = 2;
    localparam int IED_CTL_SUPP = 3;
    localparam int IED_COLL_VALID = 7;
    // ==========================================================
    // reset values and frame limits
    localparam logic [7:0] IED_IRQ_EN2_RST = 8'h00;
    localparam logic [3:0] IED_CTRL_RST = 4'h0;
    localparam logic [7:0] IED_ERR_RST = 8'h00;
    localparam logic [7:0] IED_COLL_RST = 8'h00;
    localparam logic [15:0] IED_MIN_FRAME_BITS = 16'h0004;
    localparam logic [15:0] IED_SUPP_MIN_BITS = 16'h0018;
    // ==========================================================
    // transceiver state codes, 010b and 100b unused
    typedef enum logic [2:0] {
        IED_ST_IDLE = 3'h0,
        IED_ST_TXWAIT = 3'h1,
        IED_ST_TXING = 3'h3,
        IED_ST_RXWAIT = 3'h5,
        IED_ST_WAITDATA = 3'h6,
        IED_ST_RXING = 3'h7
    } ied_state_t;

    function automatic logic [11:0] ied_byte_addr(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // true in the three receive-side states
    function automatic logic ied_in_rx(input logic [2:0] st);
        return (st == IED_ST_RXWAIT) || (st == IED_ST_WAITDATA) || (st == IED_ST_RXING);
    endfunction
endpackage

// ---- core/ied_err_flags.sv ----
// sticky error flags and first-collision position
`timescale 1ns/10ps
`default_nettype none
module ied_err_flags
    import ied_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ied_evt_if.flag_m ev
);
    // ==========================================================
    // set wins over clear on the same edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev.err_flags <= IED_ERR_RST;
        end else begin
            ev.err_flags <= (ev.err_flags & ~ev.err_clr) | ev.err_set;
        end
    end

    // only the first collision since the last clear is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev.coll_reg <= IED_COLL_RST;
        end else if (ev.coll_set && (ev.coll_clr || !ev.coll_reg[IED_COLL_VALID])) begin
            ev.coll_reg <= {1'b1, ev.coll_pos};
        end else if (ev.coll_clr) begin
            ev.coll_reg <= IED_COLL_RST;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_flag_held: assert property ((ev.err_flags[0] && !ev.err_clr[0])
        |=> ev.err_flags[0])
        else $error("flag dropped without a clear");
endmodule
`default_nettype wire

// ---- core/ied_irq_gate.sv ----
// combined interrupt request and interrupt pin driver
`timescale 1ns/10ps
`default_nettype none
module ied_irq_gate
    import ied_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    ied_evt_if.irq_m ev
);
    logic comb_nxt;
    logic level_nxt;

    // enabled requests only
    assign comb_nxt = (ev.req_cd & ev.irq_en2[IED_EN_CD]) | (|(ev.req_tmr & ev.irq_en2[4:0]));
    // gate, then polarity
    assign level_nxt = (comb_nxt & ev.irq_en2[IED_EN_GATE]) ^ ev.irq_inv;

    // ==========================================================
    // registered pin; open drain only pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev.combined <= 1'b0;
            ev.pin_o <= 1'b0;
            ev.pin_oe <= 1'b0;
        end else begin
            ev.combined <= comb_nxt;
            ev.pin_o <= ev.irq_en2[IED_EN_DRIVE] & level_nxt;
            ev.pin_oe <= ev.irq_en2[IED_EN_DRIVE] | ~level_nxt;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_push_pull_drive: assert property (ev.irq_en2[IED_EN_DRIVE] |=> ev.pin_oe)
        else $error("push-pull pin not driven");
    a_gate_off_idle: assert property ((!ev.irq_en2[IED_EN_GATE]
        && ev.irq_en2[IED_EN_DRIVE]) |=> (ev.pin_o == $past(ev.irq_inv)))
        else $error("pin active while gate off");
endmodule
`default_nettype wire

// ---- core/ied_top.sv ----
// register bank for the second interrupt enable, error and status registers
`timescale 1ns/10ps
`default_nettype none
module ied_top
    import ied_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic card_detect_request,
    input wire logic [4:0] tmr_request,
    input wire logic [2:0] transceiver_state_in,
    input wire logic cl_cmd_start,
    input wire logic rx_cmd_start,
    input wire logic trx_cmd_active,
    input wire logic err_flags_stored,
    input wire logic nvm_cmd_start,
    input wire logic nvm_fail,
    input wire logic fifo_wr_req,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic crc_tx_active,
    input wire logic auth_active,
    input wire logic tx_request,
    input wire logic frame_end,
    input wire logic [CNT_W-1:0] frame_bit_count,
    input wire logic coll_det,
    input wire logic [6:0] coll_pos_in,
    input wire logic coll_in_eof,
    input wire logic stop_bit_err,
    input wire logic sof_err,
    input wire logic byte_count_err,
    input wire logic parity_err,
    input wire logic crc_err,
    input wire logic rx_byte_valid,
    output logic irq_pin_o,
    output logic irq_pin_oe,
    output logic combined_request,
    output logic fifo_wr_accept,
    output logic rx_done_request,
    output logic receive_decoder_en,
    output logic rx_byte_store
);
    // ==========================================================
    // internal state
    logic [7:0] irq_en2_r;
    logic [3:0] ctrl_r;
    ied_state_t state_r;
    logic [31:0] rdata_nxt;
    logic hit_nxt;
    logic acc_done;
    logic setup;
    logic prot_now;
    logic short_now;
    logic supp_now;
    logic coll_now;
    logic rx_clr_now;
    logic [7:0] err_set_nxt;
    logic [7:0] err_clr_nxt;
    logic fifo_wr_accept_r;
    logic rx_done_r;
    logic decoder_en_r;
    logic store_r;

    ied_evt_if ev();

    ied_err_flags u_flags (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ev.flag_m)
    );

    ied_irq_gate u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .ev(ev.irq_m)
    );

    // ==========================================================
    // apb decode; answer is ready in the first access cycle
    assign setup = psel && !penable;
    assign acc_done = psel && penable && pready;

    // read mux, reserved bits read as zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        hit_nxt = 1'b1;
        unique case (paddr)
            ied_byte_addr(IED_IDX_IRQ_EN2): rdata_nxt[7:0] = irq_en2_r;
            ied_byte_addr(IED_IDX_ERROR): rdata_nxt[7:0] = ev.err_flags;
            ied_byte_addr(IED_IDX_STATUS): rdata_nxt[2:0] = state_r;
            ied_byte_addr(IED_IDX_COLL): rdata_nxt[7:0] = ev.coll_reg;
            ied_byte_addr(IED_IDX_CTRL): rdata_nxt[3:0] = ctrl_r;
            default: hit_nxt = 1'b0;
        endcase
    end

    // answer flops: loaded in setup, dropped after the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
            pslverr <= !hit_nxt;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // ==========================================================
    // writable registers; error and status are not writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en2_r <= IED_IRQ_EN2_RST;
        end else if (acc_done && pwrite && paddr == ied_byte_addr(IED_IDX_IRQ_EN2)) begin
            irq_en2_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= IED_CTRL_RST;
        end else if (acc_done && pwrite && paddr == ied_byte_addr(IED_IDX_CTRL)) begin
            ctrl_r <= pwdata[3:0];
        end
    end

    // state copy; the unused codes are shown as received
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= IED_ST_IDLE;
        end else begin
            state_r <= ied_state_t'(transceiver_state_in);
        end
    end

    // ==========================================================
    // interrupt gate inputs
    assign ev.irq_en2 = irq_en2_r;
    assign ev.irq_inv = ctrl_r[IED_CTL_INV];
    assign ev.req_cd = card_detect_request;
    assign ev.req_tmr = tmr_request;

    // ==========================================================
    // receive event qualification
    assign prot_now = stop_bit_err || sof_err || byte_count_err;
    assign short_now = frame_end && (frame_bit_count < IED_MIN_FRAME_BITS);
    // suppression mode: below three bytes the receive done is withheld, the short flag is set only below four bits
    assign supp_now = frame_end && ctrl_r[IED_CTL_SUPP]
        && (frame_bit_count < IED_SUPP_MIN_BITS);
    assign coll_now = coll_det && !coll_in_eof;
    // receive cmd start, or transceive reaching wait-for-data
    assign rx_clr_now = rx_cmd_start || (trx_cmd_active
        && transceiver_state_in == IED_ST_WAITDATA && state_r != IED_ST_WAITDATA);

    // ==========================================================
    // flag set sources
    always_comb begin
        err_set_nxt = 8'h00;
        err_set_nxt[IED_ERR_NVM] = nvm_fail;
        err_set_nxt[IED_ERR_MISUSE] = fifo_wr_req && (crc_tx_active || auth_active
            || ied_in_rx(transceiver_state_in));
        err_set_nxt[IED_ERR_OVL] = fifo_wr_req && fifo_full;
        err_set_nxt[IED_ERR_SHORT] = short_now;
        err_set_nxt[IED_ERR_EMPTY] = tx_request && fifo_empty;
        err_set_nxt[IED_ERR_COLL] = coll_now;
        err_set_nxt[IED_ERR_PROT] = prot_now;
        err_set_nxt[IED_ERR_INTEG] = parity_err || crc_err
            || (coll_now && ctrl_r[IED_CTL_COLLINT]);
    end

    // flag clear sources; a coincident set still wins in the store
    always_comb begin
        err_clr_nxt = 8'h00;
        err_clr_nxt[IED_ERR_NVM] = nvm_cmd_start;
        err_clr_nxt[IED_ERR_MISUSE] = ctrl_r[IED_CTL_MRX] ? err_flags_stored
            : cl_cmd_start;
        err_clr_nxt[IED_ERR_OVL] = cl_cmd_start;
        err_clr_nxt[IED_ERR_EMPTY] = cl_cmd_start;
        err_clr_nxt[IED_ERR_SHORT] = rx_clr_now;
        err_clr_nxt[IED_ERR_COLL] = rx_clr_now;
        err_clr_nxt[IED_ERR_PROT] = rx_clr_now;
        err_clr_nxt[IED_ERR_INTEG] = rx_clr_now;
    end

    assign ev.err_set = err_set_nxt;
    assign ev.err_clr = err_clr_nxt;
    assign ev.coll_set = coll_now;
    assign ev.coll_clr = rx_clr_now;
    assign ev.coll_pos = coll_pos_in;

    // ==========================================================
    // fifo write pass; writes stop while overflow stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_wr_accept_r <= 1'b0;
        end else begin
            fifo_wr_accept_r <= fifo_wr_req && !fifo_full
                && !ev.err_flags[IED_ERR_OVL];
        end
    end

    // receive done only for frames that survive qualification
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_done_r <= 1'b0;
        end else begin
            rx_done_r <= frame_end && !short_now && !supp_now;
        end
    end

    // decoder stays on through discards; protocol fault stops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            decoder_en_r <= 1'b1;
        end else if (prot_now) begin
            decoder_en_r <= 1'b0;
        end else if (cl_cmd_start || rx_clr_now) begin
            decoder_en_r <= 1'b1;
        end
    end

    // byte store; the byte beside a protocol fault is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_r <= 1'b0;
        end else begin
            store_r <= rx_byte_valid && decoder_en_r && !prot_now;
        end
    end

    // ==========================================================
    // outputs, each from a flop
    assign irq_pin_o = ev.pin_o;
    assign irq_pin_oe = ev.pin_oe;
    assign combined_request = ev.combined;
    assign fifo_wr_accept = fifo_wr_accept_r;
    assign rx_done_request = rx_done_r;
    assign receive_decoder_en = decoder_en_r;
    assign rx_byte_store = store_r;

    // ==========================================================
    // checks
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_nvm_fault_set: assert property (nvm_fail |=> ev.err_flags[IED_ERR_NVM])
        else $error("nonvolatile fault flag not set");
    a_misuse_in_rx: assert property ((fifo_wr_req && ied_in_rx(transceiver_state_in))
        |=> ev.err_flags[IED_ERR_MISUSE])
        else $error("fifo misuse not flagged");
    a_misuse_clear: assert property ((cl_cmd_start && !ctrl_r[IED_CTL_MRX]
        && !err_set_nxt[IED_ERR_MISUSE]) |=> !ev.err_flags[IED_ERR_MISUSE])
        else $error("misuse flag not cleared");
    a_ovl_discard: assert property (ev.err_flags[IED_ERR_OVL] |=> !fifo_wr_accept)
        else $error("write accepted during overflow");
    a_short_no_done: assert property (short_now |=> !rx_done_request
        && ev.err_flags[IED_ERR_SHORT])
        else $error("short frame reported done");
    // a decoder already stopped by a protocol fault is not expected to come back here
    a_supp_no_done: assert property ((supp_now && !prot_now && receive_decoder_en)
        |=> !rx_done_request && receive_decoder_en)
        else $error("suppressed frame reported done");
    a_rx_clear: assert property ((rx_cmd_start && !prot_now)
        |=> !ev.err_flags[IED_ERR_PROT])
        else $error("protocol flag survived receive start");
    a_empty_tx: assert property ((tx_request && fifo_empty)
        |=> ev.err_flags[IED_ERR_EMPTY])
        else $error("empty transmit not flagged");
    a_eof_coll: assert property ((coll_det && coll_in_eof
        && !ev.err_flags[IED_ERR_COLL] && !ev.err_clr[IED_ERR_COLL])
        |=> !ev.err_flags[IED_ERR_COLL])
        else $error("end-symbol collision flagged");
    a_first_coll: assert property ((coll_now && !ev.coll_reg[IED_COLL_VALID]
        && !rx_clr_now) |=> ev.coll_reg == {1'b1, $past(coll_pos_in)})
        else $error("collision position not recorded");
    a_prot_stop: assert property (prot_now |=> !receive_decoder_en
        && ev.err_flags[IED_ERR_PROT])
        else $error("reception not stopped");
    a_prot_no_store: assert property (prot_now |=> !rx_byte_store)
        else $error("byte stored on protocol fault");
    a_integ_continue: assert property ((parity_err && !prot_now && receive_decoder_en
        && !cl_cmd_start) |=> receive_decoder_en && ev.err_flags[IED_ERR_INTEG])
        else $error("integrity fault handling wrong");
    a_coll_integ: assert property ((coll_now && ctrl_r[IED_CTL_COLLINT])
        |=> ev.err_flags[IED_ERR_INTEG])
        else $error("collision not mapped to integrity");
    // the answer carries the state copy seen at the setup edge
    a_status_read: assert property ((setup && !pwrite
        && paddr == ied_byte_addr(IED_IDX_STATUS)) |=> prdata == {29'h0, $past(state_r)})
        else $error("status read wrong");
    a_err_ro: assert property ((acc_done && pwrite
        && paddr == ied_byte_addr(IED_IDX_ERROR)
        && err_set_nxt == 8'h00 && err_clr_nxt == 8'h00)
        |=> $stable(ev.err_flags))
        else $error("error register changed by write");
    a_combined_req: assert property ((card_detect_request && irq_en2_r[IED_EN_CD])
        |=> combined_request)
        else $error("combined request missing");

    c_irq_pin: cover property (irq_pin_oe && combined_request);
    c_overflow: cover property (fifo_wr_req && fifo_full ##1 fifo_wr_req);
    c_short_frame: cover property (short_now);
    c_prot_stop: cover property (prot_now ##1 !receive_decoder_en);
endmodule
`default_nettype wire

// ---- verification/ied_apb_host.sv ----
// apb host model standing in for the controller that owns the registers
`timescale 1ns/10ps
`default_nettype none
module ied_apb_host (
    input wire logic pclk,
    output logic [11:0] paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ==========================================================
    // bus idle until the first transfer
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
    end
    // one transfer, request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state count assumed; the bench timeout ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
endmodule
`default_nettype wire

// ---- verification/irq1_enable_error_status_tb.sv ----
// self-checking bench for the interrupt enable, error and status registers
`timescale 1ns/10ps
`default_nettype none
module irq1_enable_error_status_tb;
    import ied_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    logic pclk = 1'b0, presetn = 1'b0, fifo_full = 1'b0, fifo_empty = 1'b0, coll_in_eof = 1'b0;
    logic trx_cmd_active = 1'b0, crc_tx_active = 1'b0, auth_active = 1'b0;
    logic [5:0] rq = '0;
    logic [14:0] pls = '0;
    logic [2:0] transceiver_state_in = '0;
    logic [15:0] frame_bit_count = '0;
    logic [6:0] coll_pos_in = '0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic psel, penable, pwrite, pready, pslverr, e, irq_pin_o, irq_pin_oe, combined_request;
    logic fifo_wr_accept, rx_done_request, receive_decoder_en, rx_byte_store;
    logic [2:0] seen;
    logic [11:0] pt [4] = '{12'h011, 12'h410, 12'hC15, 12'h817};
    wire logic card_detect_request, cl_cmd_start, rx_cmd_start, err_flags_stored, nvm_cmd_start;
    wire logic nvm_fail, fifo_wr_req, tx_request, frame_end, coll_det, stop_bit_err, sof_err;
    wire logic byte_count_err, parity_err, crc_err, rx_byte_valid;
    wire logic [4:0] tmr_request;
    int miscompares = 0, n_checks = 0, cyc = 0;
    // one bit per event pulse, so several can fire in the same cycle
    assign {card_detect_request, tmr_request} = rq;
    assign {rx_byte_valid, crc_err, parity_err, byte_count_err, sof_err, stop_bit_err, coll_det,
        frame_end, tx_request, fifo_wr_req, nvm_fail, nvm_cmd_start, err_flags_stored,
        rx_cmd_start, cl_cmd_start} = pls;
    ied_top #(.CNT_W(16)) u_dut (.*);
    ied_apb_host u_host (.*);
    // 40 MHz clock
    initial forever #12.5 pclk = ~pclk;
    // hang guard, well above the length of the sequence
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    // ==========================================================
    // helpers
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        u_host.xfer(1'b1, a, v, d, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        u_host.xfer(1'b0, a, 32'h0, d, e);
        chk(d, x);
    endtask
    // events last one cycle; pulse outputs are caught right after
    task automatic pulse(input logic [14:0] m);
        @(posedge pclk);
        pls <= m;
        @(posedge pclk);
        pls <= '0;
        #1;
        seen = {rx_byte_store, rx_done_request, fifo_wr_accept};
    endtask
    task automatic hold();
        repeat (3) @(posedge pclk);
        #1;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h028, 32'h0);
        u_host.xfer(1'b0, 12'h3F0, 32'h0, d, e);
        chk({31'h0, e}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(12'h024, {24'h0, 8'hC0 | (8'h01 << i)});
            @(posedge pclk) rq <= ~(6'h01 << i);
            hold();
            chk({31'h0, combined_request}, 32'h0);
            @(posedge pclk) rq <= 6'h01 << i;
            hold();
            chk({irq_pin_o, irq_pin_oe, combined_request}, 32'h7);
        end
        @(posedge pclk) rq <= 6'h01;
        for (int k = 0; k < 4; k++) begin
            wr(12'h040, {31'h0, pt[k][2]});
            wr(12'h024, {24'h0, pt[k][11:4]});
            hold();
            chk({irq_pin_o, irq_pin_oe}, pt[k][1:0]);
        end
        wr(12'h040, 32'h0);
        for (int k = 0; k < 8; k++) begin
            @(posedge pclk) transceiver_state_in <= k[2:0];
            rd(12'h02C, {29'h0, k[2:0]});
        end
        $display("test interrupt and status done");
        pulse(15'h0010);
        wr(12'h028, 32'h0);
        rd(12'h028, 32'h80);
        pulse(15'h0008);
        for (int k = 0; k < 6; k++) begin
            @(posedge pclk);
            transceiver_state_in <= (k < 3) ? 3'(5 + k) : 3'h0;
            {crc_tx_active, auth_active} <= {k == 3, k == 4};
            pulse(15'h0020);
            chk({29'h0, seen}, 32'h1);
            rd(12'h028, (k < 5) ? 32'h40 : 32'h0);
            pulse(15'h0001);
            rd(12'h028, 32'h0);
        end
        @(posedge pclk) fifo_full <= 1'b1;
        pulse(15'h0020);
        chk({29'h0, seen}, 32'h0);
        @(posedge pclk) fifo_full <= 1'b0;
        pulse(15'h0020);
        chk({29'h0, seen}, 32'h0);
        rd(12'h028, 32'h20);
        @(posedge pclk) fifo_empty <= 1'b1;
        pulse(15'h0041);
        rd(12'h028, 32'h8);
        @(posedge pclk) fifo_empty <= 1'b0;
        $display("test fifo flags done");
        for (int k = 0; k < 4; k++) begin
            wr(12'h040, {28'h0, k[1], 3'h0});
            @(posedge pclk) frame_bit_count <= k[1] ? 16'(23 + k[0]) : 16'(3 + k[0]);
            pulse(15'h0081);
            chk({29'h0, seen}, {30'h0, k[0], 1'b0});
            rd(12'h028, {27'h0, ~k[0] & ~k[1], 4'h0});
            pulse(15'h0002);
        end
        wr(12'h040, 32'h0);
        @(posedge pclk) coll_pos_in <= 7'h05;
        pulse(15'h0100);
        @(posedge pclk) coll_pos_in <= 7'h09;
        pulse(15'h0100);
        rd(12'h034, 32'h85);
        rd(12'h028, 32'h4);
        pulse(15'h0002);
        rd(12'h028, 32'h0);
        @(posedge pclk) coll_in_eof <= 1'b1;
        pulse(15'h0100);
        rd(12'h028, 32'h0);
        @(posedge pclk) coll_in_eof <= 1'b0;
        wr(12'h040, 32'h2);
        pulse(15'h0100);
        rd(12'h028, 32'h5);
        wr(12'h040, 32'h0);
        pulse(15'h0002);
        for (int k = 0; k < 5; k++) begin
            pulse(15'h4000 | (15'h0200 << k));
            chk({29'h0, seen}, {29'h0, k > 2, 2'h0});
            chk({31'h0, receive_decoder_en}, {31'h0, k > 2});
            rd(12'h028, (k > 2) ? 32'h1 : 32'h2);
            pulse(15'h0002);
        end
        // transceive: receive flags clear on reaching wait-for-data
        @(posedge pclk) trx_cmd_active <= 1'b1;
        pulse(15'h0200);
        rd(12'h028, 32'h2);
        @(posedge pclk) transceiver_state_in <= IED_ST_WAITDATA;
        hold();
        rd(12'h028, 32'h0);
        // multi-frame mode: misuse survives a command start, clears on flag store
        wr(12'h040, 32'h4);
        pulse(15'h0020);
        pulse(15'h0001);
        rd(12'h028, 32'h40);
        pulse(15'h0004);
        rd(12'h028, 32'h0);
        $display("test receive flags done");
        complete_run();
    end
endmodule
`default_nettype wire
